/* branch_skip_compare_unit.sv */
// Call, return, compare, skip and branch execution with a Wishbone port
//
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/100ps
// How it works
// RULE1: Pointer call pushes PC+1 and jumps to pointer, three cycles.
// RULE2: Direct call pushes PC+2 and jumps to the target word.
// RULE3: Both returns load PC from popped stack value, four cycles.
// RULE4: Only interrupt return touches flags, setting the global enable.
// RULE5: Compare-skip-equal skips next instruction on match, no flags.
// RULE6: Register compare subtracts for flags only, nothing written back.
// RULE7: Compare with borrow also subtracts current carry.
// RULE8: Compare with constant subtracts the instruction constant.
// RULE9: Compares update Z N V C H only, in one cycle.
// RULE10: Skip when selected register bit is low.
// RULE11: Skip when selected register bit is high.
// RULE12: I/O bit skips test a port bit low or high, 1/2/3 cycles.
// RULE13: Flag-high branch goes to PC plus offset plus one, 1/2 cycles.
// RULE14: Flag-low branch goes there only when the flag is zero.
// RULE15: Equal and unequal branches test zero flag, no flag change.
// RULE16: Unequal branch with zero flag clear jumps to PC+k+1.
// RULE17: False condition steps one word; skip length follows next word.
module branch_skip_compare_unit (
  input  wire logic             CLOCK,
  input  wire logic             RST_N,
  input  wire flow_pkg::wb_req_t WB_REQ,
  output logic                  WB_ACK_O,
  output logic      [31:0]      WB_DAT_O
);
  import flow_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic hit(input logic [15:0] w,
                               input logic [15:0] m,
                               input logic [15:0] v);
    hit = (w & m) == v;
  endfunction

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [15:0] pc_reg, pc_next;
  logic [15:0] instr_reg;
  logic [15:0] ext_reg;
  logic [7:0]  opd_reg;
  logic [7:0]  opr_reg;
  logic [15:0] ptr_reg;
  logic [15:0] stack_reg;
  logic [7:0]  flags_reg, flags_next;
  logic [15:0] pushed_reg, pushed_next;
  logic        bad_reg, bad_next;
  logic [2:0]  cyc_reg, cyc_next;
  logic [2:0]  cnt_reg;
  logic        go_reg;
  logic        ack_reg;
  logic [31:0] dat_reg;
  fsm_t        state_reg;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire req      = WB_REQ.cyc & WB_REQ.stb;
  wire wr_take  = req & WB_REQ.we & ack_reg;
  wire idle     = state_reg == S_IDLE;
  wire wr_pc    = wr_take & idle & (WB_REQ.adr == ADR_PC);
  wire wr_instr = wr_take & idle & (WB_REQ.adr == ADR_INSTR);
  wire wr_ext   = wr_take & (WB_REQ.adr == ADR_EXT);
  wire wr_opd   = wr_take & (WB_REQ.adr == ADR_OPD);
  wire wr_opr   = wr_take & (WB_REQ.adr == ADR_OPR);
  wire wr_ptr   = wr_take & (WB_REQ.adr == ADR_PTR);
  wire wr_stack = wr_take & (WB_REQ.adr == ADR_STACK);
  wire wr_flags = wr_take & idle & (WB_REQ.adr == ADR_FLAGS);

  wire [7:0] state_word = {1'b0, cyc_reg, 2'b00, bad_reg, ~idle};

  logic [31:0] rd_mux;
  always_comb begin
    unique case (WB_REQ.adr)
      ADR_PC:     rd_mux = {16'h0000, pc_reg};
      ADR_INSTR:  rd_mux = {16'h0000, instr_reg};
      ADR_EXT:    rd_mux = {16'h0000, ext_reg};
      ADR_OPD:    rd_mux = {24'h000000, opd_reg};
      ADR_OPR:    rd_mux = {24'h000000, opr_reg};
      ADR_PTR:    rd_mux = {16'h0000, ptr_reg};
      ADR_STACK:  rd_mux = {16'h0000, stack_reg};
      ADR_FLAGS:  rd_mux = {24'h000000, flags_reg};
      ADR_STATE:  rd_mux = {24'h000000, state_word};
      ADR_PUSHED: rd_mux = {16'h0000, pushed_reg};
      default:    rd_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  wire op_pcall               = instr_reg == OP_PTR_CALL;
  wire op_call                = hit(instr_reg, M_CALL, V_CALL);
  wire op_ret                 = instr_reg == OP_RET;
  wire op_iret                = instr_reg == OP_INT_RET;
  wire compare_skip_equal_op  = hit(instr_reg, M_RR, V_CMP_SKIP);
  wire op_cp                  = hit(instr_reg, M_RR, V_CP);
  wire compare_with_borrow_op = hit(instr_reg, M_RR, V_CMP_BORROW);
  wire compare_constant_op    = hit(instr_reg, M_IMM, V_CMP_CONST);
  wire op_srbl  = hit(instr_reg, M_RBIT, V_SRBL);
  wire op_srbh  = hit(instr_reg, M_RBIT, V_SRBH);
  wire op_siol  = hit(instr_reg, M_IOB, V_SIOL);
  wire op_sioh  = hit(instr_reg, M_IOB, V_SIOH);
  wire op_brh   = hit(instr_reg, M_RR, V_BRH);
  wire op_brl   = hit(instr_reg, M_RR, V_BRL);

  wire [2:0]  bit_sel  = instr_reg[2:0];
  wire [7:0]  imm      = {instr_reg[11:8], instr_reg[3:0]};
  wire [15:0] offset   = {{9{instr_reg[9]}}, instr_reg[9:3]};
  wire        opr_bit  = opr_reg[bit_sel];
  wire        flag_bit = flags_reg[bit_sel];

  // ----------------------------------------
  // Compare and skip length
  // ----------------------------------------
  wire       is_cmp   = op_cp | compare_with_borrow_op | compare_constant_op;
  wire [7:0] cmp_b    = compare_constant_op ? imm : opr_reg;
  wire       use_c    = compare_with_borrow_op & flags_reg[FL_C];
  wire       chain_z  = ~compare_with_borrow_op | flags_reg[FL_Z];
  logic [7:0] cmp_flags;
  logic       ext_long;

  compare_flags u_cmp (
    .a          (opd_reg),
    .b          (cmp_b),
    .borrow_in  (use_c),
    .chain_zero (chain_z),
    .flags_in   (flags_reg),
    .flags_out  (cmp_flags)
  );

  next_word_len u_len (
    .word      (ext_reg),
    .two_words (ext_long)
  );

  wire skip_op   = compare_skip_equal_op | op_srbl | op_srbh | op_siol | op_sioh;
  wire skip_true = (compare_skip_equal_op & (opd_reg == opr_reg))  // [RULE5]
                 | (op_srbl & ~opr_bit)              // [RULE10]
                 | (op_srbh & opr_bit)               // [RULE11]
                 | (op_siol & ~opr_bit)              // [RULE12]
                 | (op_sioh & opr_bit);              // [RULE12]
  wire br_op     = op_brh | op_brl;
  // Bit 1 selects zero flag for equal and unequal forms
  wire br_true   = (op_brh & flag_bit)               // [RULE13] [RULE15]
                 | (op_brl & ~flag_bit);             // [RULE14] [RULE16]

  wire [15:0] pc_step  = pc_reg + 16'h0001;
  wire [15:0] pc_skip  = pc_reg + (ext_long ? 16'h0003 : 16'h0002);
  wire [15:0] pc_rel   = pc_reg + offset + 16'h0001;
  wire [15:0] pc_after = pc_reg + 16'h0002;

  // ----------------------------------------
  // Result selection
  // ----------------------------------------
  always_comb begin
    pc_next     = pc_step;
    flags_next  = flags_reg;
    pushed_next = pushed_reg;
    cyc_next    = CYC_ONE;
    bad_next    = 1'b0;
    if (op_pcall) begin
      pushed_next = pc_step;                         // [RULE1]
      pc_next     = ptr_reg;                         // [RULE1]
      cyc_next    = CYC_PCALL;                       // [RULE1]
    end else if (op_call) begin
      pushed_next = pc_after;                        // [RULE2]
      pc_next     = ext_reg;                         // [RULE2]
      cyc_next    = CYC_CALL;
    end else if (op_ret | op_iret) begin
      pc_next     = stack_reg;                       // [RULE3]
      cyc_next    = CYC_RET;                         // [RULE3]
      if (op_iret) begin
        flags_next[FL_I] = 1'b1;                     // [RULE4]
      end
    end else if (is_cmp) begin
      flags_next  = cmp_flags;                       // [RULE6] [RULE7] [RULE8] [RULE9]
      cyc_next    = CYC_ONE;                         // [RULE9]
    end else if (skip_op) begin
      if (skip_true) begin
        pc_next   = pc_skip;                         // [RULE17]
        cyc_next  = ext_long ? CYC_THREE : CYC_TWO;  // [RULE5] [RULE12]
      end
    end else if (br_op) begin
      if (br_true) begin
        pc_next   = pc_rel;                          // [RULE13] [RULE16]
        cyc_next  = CYC_TWO;                         // [RULE13]
      end
    end else begin
      bad_next    = 1'b1;
    end
  end

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= req & ~ack_reg;
      dat_reg <= rd_mux;
    end
  end

  // ----------------------------------------
  // Operand registers
  // ----------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      instr_reg <= 16'h0000;
      ext_reg   <= 16'h0000;
      opd_reg   <= 8'h00;
      opr_reg   <= 8'h00;
      ptr_reg   <= 16'h0000;
      stack_reg <= 16'h0000;
    end else begin
      if (wr_instr) instr_reg <= merge16(instr_reg, WB_REQ.dat, WB_REQ.sel);
      if (wr_ext)   ext_reg   <= merge16(ext_reg, WB_REQ.dat, WB_REQ.sel);
      if (wr_opd && WB_REQ.sel[0]) opd_reg <= WB_REQ.dat[7:0];
      if (wr_opr && WB_REQ.sel[0]) opr_reg <= WB_REQ.dat[7:0];
      if (wr_ptr)   ptr_reg   <= merge16(ptr_reg, WB_REQ.dat, WB_REQ.sel);
      if (wr_stack) stack_reg <= merge16(stack_reg, WB_REQ.dat, WB_REQ.sel);
    end
  end

  // ----------------------------------------
  // Execution sequencer
  // ----------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state_reg <= S_IDLE;
      go_reg    <= 1'b0;
      cnt_reg   <= 3'h0;
      cyc_reg   <= 3'h0;
      bad_reg   <= 1'b0;
    end else begin
      go_reg <= wr_instr;
      unique case (state_reg)
        S_IDLE: begin
          if (go_reg) begin
            state_reg <= S_EXEC;
            cnt_reg   <= cyc_next - CYC_ONE;
            cyc_reg   <= cyc_next;
            bad_reg   <= bad_next;
          end
        end
        S_EXEC: begin
          if (cnt_reg == 3'h0) begin
            state_reg <= S_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 3'h1;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Architectural state commit
  // ----------------------------------------
  wire commit = (state_reg == S_EXEC) & (cnt_reg == 3'h0);
  logic [15:0] pc_hold;
  logic [7:0]  flags_hold;
  logic [15:0] pushed_hold;

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      pc_hold     <= PC_RST;
      flags_hold  <= FLAGS_RST;
      pushed_hold <= 16'h0000;
    end else if (idle && go_reg) begin
      pc_hold     <= pc_next;
      flags_hold  <= flags_next;
      pushed_hold <= pushed_next;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      pc_reg     <= PC_RST;
      flags_reg  <= FLAGS_RST;
      pushed_reg <= 16'h0000;
    end else if (commit) begin
      pc_reg     <= pc_hold;
      flags_reg  <= flags_hold;
      pushed_reg <= pushed_hold;
    end else begin
      if (wr_pc) pc_reg <= merge16(pc_reg, WB_REQ.dat, WB_REQ.sel);
      if (wr_flags && WB_REQ.sel[0]) flags_reg <= WB_REQ.dat[7:0];
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = dat_reg;
endmodule

/* flow_pkg.sv */
// Shared constants, encodings and carriers for the flow unit
package flow_pkg;
  // ----------------------------------------
  // Bus register offsets
  // ----------------------------------------
  localparam logic [7:0] ADR_PC     = 8'h00;
  localparam logic [7:0] ADR_INSTR  = 8'h04;
  localparam logic [7:0] ADR_EXT    = 8'h08;
  localparam logic [7:0] ADR_OPD    = 8'h0C;
  localparam logic [7:0] ADR_OPR    = 8'h10;
  localparam logic [7:0] ADR_PTR    = 8'h14;
  localparam logic [7:0] ADR_STACK  = 8'h18;
  localparam logic [7:0] ADR_FLAGS  = 8'h1C;
  localparam logic [7:0] ADR_STATE  = 8'h20;
  localparam logic [7:0] ADR_PUSHED = 8'h24;
  // ----------------------------------------
  // Status flag positions and reset values
  // ----------------------------------------
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_H = 5;
  localparam int FL_I = 7;
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [15:0] PC_RST    = 16'h0000;
  // State register fields
  localparam int ST_BUSY = 0;
  localparam int ST_BAD  = 1;
  localparam int ST_CYC  = 4;
  // ----------------------------------------
  // Opcode masks and matches
  // ----------------------------------------
  localparam logic [15:0] OP_PTR_CALL = 16'h9509;
  localparam logic [15:0] OP_RET      = 16'h9508;
  localparam logic [15:0] OP_INT_RET  = 16'h9518;
  localparam logic [15:0] M_CALL   = 16'hFE0E;
  localparam logic [15:0] V_CALL   = 16'h940E;
  localparam logic [15:0] M_JMP    = 16'hFE0C;
  localparam logic [15:0] V_JMP    = 16'h940C;
  localparam logic [15:0] M_LDS    = 16'hFC0F;
  localparam logic [15:0] V_LDS    = 16'h9000;
  localparam logic [15:0] M_RR     = 16'hFC00;
  localparam logic [15:0] V_CMP_SKIP   = 16'h1000;
  localparam logic [15:0] V_CP         = 16'h1400;
  localparam logic [15:0] V_CMP_BORROW = 16'h0400;
  localparam logic [15:0] M_IMM        = 16'hF000;
  localparam logic [15:0] V_CMP_CONST  = 16'h3000;
  localparam logic [15:0] M_RBIT   = 16'hFE08;
  localparam logic [15:0] V_SRBL   = 16'hFC00;
  localparam logic [15:0] V_SRBH   = 16'hFE00;
  localparam logic [15:0] M_IOB    = 16'hFF00;
  localparam logic [15:0] V_SIOL   = 16'h9900;
  localparam logic [15:0] V_SIOH   = 16'h9B00;
  localparam logic [15:0] V_BRH    = 16'hF000;
  localparam logic [15:0] V_BRL    = 16'hF400;
  // ----------------------------------------
  // Cycle counts
  // ----------------------------------------
  localparam logic [2:0] CYC_PCALL = 3'h3;
  localparam logic [2:0] CYC_CALL  = 3'h4;
  localparam logic [2:0] CYC_RET   = 3'h4;
  localparam logic [2:0] CYC_ONE   = 3'h1;
  localparam logic [2:0] CYC_TWO   = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'b01,
    S_EXEC = 2'b10
  } fsm_t;
endpackage

/* compare_flags.sv */
// Subtract-for-flags unit used by the register, borrow and constant compare forms
`timescale 1ns/100ps
module compare_flags (
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       borrow_in,
  input  wire logic       chain_zero,
  input  wire logic [7:0] flags_in,
  output logic      [7:0] flags_out
);
  import flow_pkg::*;
  wire [7:0] diff = a - b - {7'h00, borrow_in};
  wire       h    = (~a[3] & b[3]) | (b[3] & diff[3]) | (diff[3] & ~a[3]);
  wire       v    = (a[7] & ~b[7] & ~diff[7]) | (~a[7] & b[7] & diff[7]);
  wire       c    = (~a[7] & b[7]) | (b[7] & diff[7]) | (diff[7] & ~a[7]);
  wire       z    = (diff == 8'h00) & chain_zero;
  // Only Z N V C H move; difference is dropped
  always_comb begin
    flags_out       = flags_in;
    flags_out[FL_Z] = z;
    flags_out[FL_N] = diff[7];
    flags_out[FL_V] = v;
    flags_out[FL_C] = c;
    flags_out[FL_H] = h;
  end
endmodule

/* next_word_len.sv */
// Tells whether an instruction word opens a two-word instruction
`timescale 1ns/100ps
module next_word_len (
  input  wire logic [15:0] word,
  output logic             two_words
);
  import flow_pkg::*;
  // Long forms: absolute call, jump, direct load and store
  wire is_call = (word & M_CALL) == V_CALL;
  wire is_jmp  = (word & M_JMP) == V_JMP;
  wire is_lds  = (word & M_LDS) == V_LDS;
  wire is_sts  = (word & M_LDS) == (V_LDS | 16'h0200);
  assign two_words = is_call | is_jmp | is_lds | is_sts;
endmodule

/* flow_sva.sv */
// Port checker for the flow unit
`timescale 1ns/100ps
module flow_sva (
  input wire logic              CLOCK,
  input wire logic              RST_N,
  input wire flow_pkg::wb_req_t WB_REQ,
  input wire logic              WB_ACK_O,
  input wire logic [31:0]       WB_DAT_O
);
  import flow_pkg::*;
  logic [15:0] op_reg;
  wire rd_ack = WB_ACK_O && !WB_REQ.we;
  wire st_rd  = rd_ack && WB_REQ.adr == ADR_STATE && !WB_DAT_O[ST_BUSY];
  wire is_cmp = (op_reg & M_RR) == V_CP || (op_reg & M_RR) == V_CMP_BORROW ||
                (op_reg & M_IMM) == V_CMP_CONST;
  // Last instruction started
  always_ff @(posedge CLOCK) begin
    if (!RST_N)
      op_reg <= 16'h0000;
    else if (WB_ACK_O && WB_REQ.we && WB_REQ.adr == ADR_INSTR)
      op_reg <= WB_REQ.dat[15:0];
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  ack_after_req_a: assert property (WB_REQ.cyc && WB_REQ.stb && !WB_ACK_O |=> WB_ACK_O)
    else $error("ack missing after request");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  ack_in_cycle_a: assert property (WB_ACK_O |-> WB_REQ.cyc && WB_REQ.stb)
    else $error("ack without request");
  unmapped_zero_a: assert property (rd_ack && WB_REQ.adr > ADR_PUSHED |-> WB_DAT_O == 32'h0)
    else $error("unmapped read not zero");
  flags_width_a: assert property (rd_ack && WB_REQ.adr == ADR_FLAGS |-> WB_DAT_O[31:8] == 24'h0)
    else $error("flags upper bits not zero");
  pcall_cycles_a: assert property (st_rd && op_reg == OP_PTR_CALL |-> WB_DAT_O[6:4] == CYC_PCALL)
    else $error("pointer call cycle count wrong");
  ret_cycles_a: assert property (st_rd && (op_reg == OP_RET || op_reg == OP_INT_RET)
    |-> WB_DAT_O[6:4] == CYC_RET)
    else $error("return cycle count wrong");
  cmp_cycles_a: assert property (st_rd && is_cmp |-> WB_DAT_O[6:4] == CYC_ONE)
    else $error("compare cycle count wrong");
  cover property (st_rd && op_reg == OP_PTR_CALL);
  cover property (st_rd && is_cmp);
  cover property (WB_ACK_O && WB_REQ.we);
endmodule
bind branch_skip_compare_unit flow_sva chk (.CLOCK(CLOCK), .RST_N(RST_N), .WB_REQ(WB_REQ),
  .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O));

/* prog_mem.sv */
// Program memory model holding instruction and following words
`timescale 1ns/100ps
module prog_mem (
  input  wire logic [4:0]  addr,
  output logic      [15:0] word
);
  // Even entry: instruction, odd entry: word after it
  localparam logic [15:0] ROM [32] = '{
    16'h1000, 16'h0000, 16'h1000, 16'h0000, 16'hFC03, 16'h940E, 16'hFE07, 16'h9000,
    16'hFE00, 16'h0000, 16'h9905, 16'h0000, 16'h9B02, 16'h940C, 16'hF028, 16'h0000,
    16'hF028, 16'h0000, 16'hF7EA, 16'h0000, 16'hF7EA, 16'h0000, 16'hF029, 16'h0000,
    16'hF7E9, 16'h0000, 16'hF7E9, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  assign word = ROM[addr];
endmodule

/* tb_branch_skip_compare_unit.sv */
// Self-checking bench for the flow unit
`timescale 1ns/100ps
module tb_branch_skip_compare_unit;
  import flow_pkg::*;
  logic        CLOCK;
  logic        RST_N;
  wb_req_t     WB_REQ;
  logic        WB_ACK_O;
  logic [31:0] WB_DAT_O;
  logic [4:0]  rom_addr;
  logic [15:0] rom_word;
  int          miscompares;
  int          compares;
  // Rd, Rr, flags, expected PC, cycles
  logic [47:0] cases [14] = '{
    48'h55553F020202, 48'h55543F020101, 48'h00F73F020303, 48'h00803F020303,
    48'h00FE3F020101, 48'h00DF3F020202, 48'h00043F020303, 48'h000001020602,
    48'h000000020101, 48'h00000001FE02, 48'h000004020101, 48'h000002020602,
    48'h00000001FE02, 48'h000002020101};
  branch_skip_compare_unit dut (.CLOCK(CLOCK), .RST_N(RST_N), .WB_REQ(WB_REQ),
    .WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O));
  prog_mem rom (.addr(rom_addr), .word(rom_word));
  always #10 CLOCK = ~CLOCK;
  task automatic tally_and_finish();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge CLOCK);
    WB_REQ <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: d};
    do begin
      @(posedge CLOCK);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 20);
    if (WB_ACK_O !== 1'b1) begin
      miscompares++;
      tally_and_finish();
    end
    q = WB_DAT_O;
    WB_REQ <= '0;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, adr, d, q);
  endtask
  task automatic rd(input logic [7:0] adr, output logic [31:0] q);
    wb(1'b0, adr, 32'h0, q);
  endtask
  task automatic run_op(input logic [15:0] op, output logic [15:0] pc,
                        output logic [7:0] fl, output logic [2:0] cy);
    logic [31:0] q;
    int n;
    wr(ADR_INSTR, {16'h0, op});
    n = 0;
    do begin
      rd(ADR_STATE, q);
      n++;
    end while (q[ST_BUSY] !== 1'b0 && n < 20);
    if (q[ST_BUSY] !== 1'b0) begin
      miscompares++;
      tally_and_finish();
    end
    cy = q[6:4];
    rd(ADR_PC, q);
    pc = q[15:0];
    rd(ADR_FLAGS, q);
    fl = q[7:0];
  endtask
  task automatic test_reset();
    logic [31:0] q;
    rd(ADR_PC, q);
    check("pc reset", q, {16'h0, PC_RST});
    rd(ADR_FLAGS, q);
    check("flags reset", q, {24'h0, FLAGS_RST});
    wr(8'h40, 32'hFFFF);
    rd(8'h40, q);
    check("unmapped", q, 32'h0);
  endtask
  task automatic test_calls();
    logic [15:0] pc;
    logic [7:0]  fl;
    logic [2:0]  cy;
    logic [31:0] q;
    wr(ADR_PC, 32'h0100);
    wr(ADR_PTR, 32'h1234);
    run_op(OP_PTR_CALL, pc, fl, cy);
    check("pcall pc", {16'h0, pc}, 32'h1234);
    check("pcall cycles", {29'h0, cy}, {29'h0, CYC_PCALL});
    check("pcall flags", {24'h0, fl}, 32'h0);
    rd(ADR_PUSHED, q);
    check("pcall pushed", q, 32'h0101);
    wr(ADR_PC, 32'h0100);
    wr(ADR_EXT, 32'h0456);
    run_op(V_CALL, pc, fl, cy);
    check("call pc", {16'h0, pc}, 32'h0456);
    check("call cycles", {29'h0, cy}, {29'h0, CYC_CALL});
    rd(ADR_PUSHED, q);
    check("call pushed", q, 32'h0102);
  endtask
  task automatic test_returns();
    logic [15:0] pc;
    logic [7:0]  fl;
    logic [2:0]  cy;
    wr(ADR_FLAGS, 32'h3F);
    wr(ADR_STACK, 32'h0777);
    run_op(OP_RET, pc, fl, cy);
    check("ret pc", {16'h0, pc}, 32'h0777);
    check("ret cycles", {29'h0, cy}, {29'h0, CYC_RET});
    check("ret flags", {24'h0, fl}, 32'h3F);
    wr(ADR_STACK, 32'h0888);
    run_op(OP_INT_RET, pc, fl, cy);
    check("interrupt_return_op pc", {16'h0, pc}, 32'h0888);
    check("interrupt_return_op flags", {24'h0, fl}, 32'hBF);
  endtask
  task automatic cmp_case(input logic [15:0] op, input logic [7:0] a, input logic [7:0] b,
                          input logic [7:0] f0, input logic [7:0] fe);
    logic [15:0] pc;
    logic [7:0]  fl;
    logic [2:0]  cy;
    logic [31:0] q;
    wr(ADR_FLAGS, {24'h0, f0});
    wr(ADR_OPD, {24'h0, a});
    wr(ADR_OPR, {24'h0, b});
    wr(ADR_PC, 32'h0300);
    run_op(op, pc, fl, cy);
    check("cmp flags", {24'h0, fl}, {24'h0, fe});
    check("cmp pc", {16'h0, pc}, 32'h0301);
    check("cmp cycles", {29'h0, cy}, {29'h0, CYC_ONE});
    rd(ADR_OPD, q);
    check("cmp operand", q, {24'h0, a});
  endtask
  task automatic test_compares();
    cmp_case(V_CP, 8'h10, 8'h20, 8'h00, 8'h05);
    cmp_case(V_CP, 8'h33, 8'h33, 8'h10, 8'h12);
    cmp_case(V_CMP_BORROW, 8'h05, 8'h05, 8'h01, 8'h25);
    cmp_case(V_CMP_BORROW, 8'h05, 8'h05, 8'h00, 8'h00);
    cmp_case(16'h3800, 8'h7F, 8'h00, 8'h00, 8'h0D);
  endtask
  task automatic run_case(input int i);
    logic [47:0] t;
    logic [15:0] pc;
    logic [7:0]  fl;
    logic [2:0]  cy;
    t = cases[i];
    rom_addr = 5'(2 * i + 1);
    @(posedge CLOCK);
    wr(ADR_EXT, {16'h0, rom_word});
    wr(ADR_OPD, {24'h0, t[47:40]});
    wr(ADR_OPR, {24'h0, t[39:32]});
    wr(ADR_FLAGS, {24'h0, t[31:24]});
    wr(ADR_PC, 32'h0200);
    rom_addr = 5'(2 * i);
    @(posedge CLOCK);
    run_op(rom_word, pc, fl, cy);
    check("flow pc", {16'h0, pc}, {16'h0, t[23:8]});
    check("flow pc", {16'h0, pc}, {16'h0, t[23:8]});
    check("flow flags", {24'h0, fl}, {24'h0, t[31:24]});
    check("flow cycles", {29'h0, cy}, {29'h0, t[2:0]});
  endtask
  task automatic test_skips();
    for (int i = 0; i < 7; i++) begin
      run_case(i);
    end
  endtask
  task automatic test_branches();
    for (int i = 7; i < 14; i++) begin
      run_case(i);
    end
  endtask
  initial begin
    CLOCK = 1'b0;
    RST_N = 1'b0;
    WB_REQ = '0;
    rom_addr = 5'h00;
    miscompares = 0;
    compares = 0;
    repeat (6) @(posedge CLOCK);
    RST_N <= 1'b1;
    test_reset();
    test_calls();
    test_returns();
    test_compares();
    test_skips();
    test_branches();
    tally_and_finish();
  end
endmodule
